// ---- include/rtctrm_pkg.sv ----
package rtctrm_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] A_OFS_TRIM = 8'h00;
   localparam logic [7:0] A_TMP_TRIM = 8'h04;
   localparam logic [7:0] A_CNT_B0   = 8'h08;
   localparam logic [7:0] A_CNT_B1   = 8'h0c;
   localparam logic [7:0] A_CTRL     = 8'h10;

   // ==========================================================
   // Field positions
   localparam int B_SIGN = 15;
   localparam int B_TRDY = 14;
   localparam int B_TOK  = 13;
   localparam int B_MODE = 0;
   localparam int B_HOLD = 1;

   // ==========================================================
   // Reset values
   localparam logic       RST_SIGN = 1'b0;
   localparam logic [7:0] RST_MAG  = 8'h00;
   localparam logic       RST_TRDY = 1'b1;
   localparam logic       RST_TOK  = 1'b0;
   localparam logic       RST_MODE = 1'b1;
   localparam logic       RST_HOLD = 1'b1;
   localparam logic [7:0] RST_CNT  = 8'h00;

   // ==========================================================
   // Trim limits and timing
   localparam logic [7:0] MAG_LIMIT     = 8'hf0;
   localparam int         CLK_HZ_DEF    = 100000000;
   localparam int         PPM_DIV       = 1000000;
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         TC_UPDATE_NS  = 40;
   localparam int         TC_UPDATE_CYC =
      (TC_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Bus slave states
   typedef enum logic [1:0] {
      BS_IDLE,
      BS_WDATA,
      BS_RWAIT
   } rtctrm_bus_t;

endpackage

// ---- hdl/rtctrm_tick.sv ----
`timescale 1ns/10ps
module rtctrm_tick
   import rtctrm_pkg::*;
#(
   parameter int CLK_HZ = CLK_HZ_DEF
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic signed [9:0] i_corr,
   output logic                   o_tick
);

   // ==========================================================
   // Trimmed one-second period; product first, so that a slow clock
   // still keeps its ppm resolution
   localparam longint CLK_L = longint'(CLK_HZ);
   localparam longint PPM_L = longint'(PPM_DIV);

   logic [31:0] period;
   logic [31:0] cnt_r;

   // Positive correction shortens the period, so the rate goes up
   always_comb begin
      period = 32'(CLK_L - longint'(i_corr) * CLK_L / PPM_L); // see RULE_14
   end

   // Period counter; >= lets a shortened period end at once
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r  <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else if (cnt_r >= period - 32'h0000_0001) begin
         cnt_r  <= 32'h0000_0000;
         o_tick <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 32'h0000_0001;
         o_tick <= 1'b0;
      end
   end

endmodule

// ---- hdl/rtctrm_top.sv ----
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps
// Functional notes
// RULE_01: Offset trim bit 15 is its sign; 0 trims down, 1 trims up.
// RULE_02: Offset magnitude bits 7-0 move the rate about 1 ppm per step.
// RULE_03: Both trims cap at 240 ppm; larger written magnitudes are dropped.
// RULE_04: Unused upper bits of both trim registers read as zero.
// RULE_05: Temperature trim bit 15 is its sign; 0 down, 1 up.
// RULE_06: Temperature magnitude bits 7-0 move the rate about 1 ppm a step.
// RULE_07: Bit 14 of temperature trim shows write-ready and resets to one.
// RULE_08: Software avoids writing the magnitude while ready reads zero.
// RULE_09: Bit 13 of temperature trim shows whether the last write took.
// RULE_10: A sign written to the upper byte commits only with the low byte.
// RULE_11: Trim fields reset from the auxiliary supply monitor, not reset.
// RULE_12: In counter mode two byte registers show the count's low bytes.
// RULE_13: Counter mode is chosen when the mode select bit is zero.
// RULE_14: The summed signed trims shape the one-second tick period.
module rtctrm_top
   import rtctrm_pkg::*;
#(
   parameter int CLK_HZ = CLK_HZ_DEF
) (
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_ARST_N,
   input  wire logic        I_AUX_RST_N,
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic      [31:0] O_HRDATA,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   output logic             O_SEC_TICK
);

   // ==========================================================
   // Reset synchronisers
   logic rst_meta_r;
   logic rst_n;
   logic aux_meta_r;
   logic aux_rst_n;

   // Core reset released through two flops
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Supply monitor reset released the same way
   always_ff @(posedge I_CORE_CLK or negedge I_AUX_RST_N) begin
      if (!I_AUX_RST_N) begin
         aux_meta_r <= 1'b0;
         aux_rst_n  <= 1'b0;
      end else begin
         aux_meta_r <= 1'b1;
         aux_rst_n  <= aux_meta_r;
      end
   end

   // ==========================================================
   // Bus slave state
   rtctrm_bus_t bus_r;
   logic [7:0]  addr_r;
   logic [3:0]  lane_r;
   logic        accept;
   logic [3:0]  lane_nxt;
   logic        wr_go;
   logic [31:0] rd_val;

   // Register contents
   logic        ofs_sign_r;
   logic [7:0]  ofs_mag_r;
   logic        tmp_sign_r;
   logic        tmp_pend_r;
   logic [7:0]  tmp_mag_r;
   logic        tmp_rdy_r;
   logic        tmp_ok_r;
   logic [2:0]  tmp_busy_r;
   logic [15:0] cnt_r;
   logic        mode_r;
   logic        hold_r;
   logic        tick;

   // Address phase taken when the bus is ready
   assign accept = I_HSEL && I_HTRANS[1] && I_HREADY;

   // Byte lanes from size and low address bits
   always_comb begin
      case (I_HSIZE)
         3'h0: lane_nxt = 4'h1 << I_HADDR[1:0];
         3'h1: lane_nxt = I_HADDR[1] ? 4'hc : 4'h3;
         default: lane_nxt = 4'hf;
      endcase
   end

   // Write data applied in the data phase
   assign wr_go = (bus_r == BS_WDATA);

   // ==========================================================
   // Bus sequencing: writes take no wait, reads take one
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         bus_r       <= BS_IDLE;
         addr_r      <= 8'h00;
         lane_r      <= 4'h0;
         O_HREADYOUT <= 1'b1;
      end else begin
         case (bus_r)
            BS_RWAIT: begin
               bus_r       <= BS_IDLE;
               O_HREADYOUT <= 1'b1;
            end
            default: begin
               if (accept) begin
                  addr_r <= {I_HADDR[7:2], 2'b00}; // Word address
                  lane_r <= lane_nxt;
                  if (I_HWRITE) begin
                     bus_r <= BS_WDATA;
                  end else begin
                     bus_r       <= BS_RWAIT;
                     O_HREADYOUT <= 1'b0;
                  end
               end else begin
                  bus_r <= BS_IDLE;
               end
            end
         endcase
      end
   end

   // Response is always OKAY
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_HRESP <= 1'b0;
      end else begin
         O_HRESP <= 1'b0;
      end
   end

   // ==========================================================
   // Read multiplexer; unused bits and unmapped words are zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (addr_r)
         A_OFS_TRIM: begin
            rd_val[B_SIGN] = ofs_sign_r;   // see RULE_04
            rd_val[7:0]    = ofs_mag_r;
         end
         A_TMP_TRIM: begin
            rd_val[B_SIGN] = tmp_sign_r;   // see RULE_04
            rd_val[B_TRDY] = tmp_rdy_r;
            rd_val[B_TOK]  = tmp_ok_r;
            rd_val[7:0]    = tmp_mag_r;
         end
         A_CNT_B0: begin
            rd_val[7:0] = cnt_r[7:0];      // see RULE_12
         end
         A_CNT_B1: begin
            rd_val[7:0] = cnt_r[15:8];     // see RULE_12
         end
         A_CTRL: begin
            rd_val[B_MODE] = mode_r;
            rd_val[B_HOLD] = hold_r;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // Read data captured in the wait cycle, after any prior write
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_HRDATA <= 32'h0000_0000;
      end else if (bus_r == BS_RWAIT) begin
         O_HRDATA <= rd_val;
      end
   end

   // ==========================================================
   // Offset trim, kept by the supply monitor reset only
   always_ff @(posedge I_CORE_CLK or negedge aux_rst_n) begin
      if (!aux_rst_n) begin
         ofs_sign_r <= RST_SIGN;           // see RULE_11
         ofs_mag_r  <= RST_MAG;            // see RULE_11
      end else if (wr_go && addr_r == A_OFS_TRIM) begin
         if (lane_r[1]) begin
            ofs_sign_r <= I_HWDATA[B_SIGN]; // see RULE_01
         end
         // Magnitudes past the limit leave the old value
         if (lane_r[0] && I_HWDATA[7:0] <= MAG_LIMIT) begin
            ofs_mag_r <= I_HWDATA[7:0];    // see RULE_02, see RULE_03
         end
      end
   end

   // ==========================================================
   // Temperature trim: upper byte stages the sign,
   // the low byte write commits sign and magnitude together
   always_ff @(posedge I_CORE_CLK or negedge aux_rst_n) begin
      if (!aux_rst_n) begin
         tmp_pend_r <= RST_SIGN;
      end else if (wr_go && addr_r == A_TMP_TRIM && lane_r[1]) begin
         tmp_pend_r <= I_HWDATA[B_SIGN];   // see RULE_10
      end
   end

   // Commit of a low byte write, refused when busy or too large
   always_ff @(posedge I_CORE_CLK or negedge aux_rst_n) begin
      if (!aux_rst_n) begin
         tmp_sign_r <= RST_SIGN;           // see RULE_11
         tmp_mag_r  <= RST_MAG;            // see RULE_11
         tmp_ok_r   <= RST_TOK;
      end else if (wr_go && addr_r == A_TMP_TRIM && lane_r[0]) begin
         if (tmp_rdy_r && I_HWDATA[7:0] <= MAG_LIMIT) begin
            tmp_mag_r <= I_HWDATA[7:0];    // see RULE_06, see RULE_03
            tmp_ok_r  <= 1'b1;             // see RULE_09
            // A word write carries its own sign
            if (lane_r[1]) begin
               tmp_sign_r <= I_HWDATA[B_SIGN]; // see RULE_05
            end else begin
               tmp_sign_r <= tmp_pend_r;   // see RULE_10
            end
         end else begin
            tmp_ok_r <= 1'b0;              // see RULE_09, see RULE_08
         end
      end
   end

   // Ready drops for the update time after an accepted commit
   always_ff @(posedge I_CORE_CLK or negedge aux_rst_n) begin
      if (!aux_rst_n) begin
         tmp_rdy_r  <= RST_TRDY;           // see RULE_07
         tmp_busy_r <= 3'h0;
      end else if (wr_go && addr_r == A_TMP_TRIM && lane_r[0]
                   && tmp_rdy_r && I_HWDATA[7:0] <= MAG_LIMIT) begin
         tmp_rdy_r  <= 1'b0;               // see RULE_07
         tmp_busy_r <= 3'(TC_UPDATE_CYC);
      end else if (tmp_busy_r > 3'h1) begin
         tmp_busy_r <= tmp_busy_r - 3'h1;
      end else if (tmp_busy_r == 3'h1) begin
         tmp_busy_r <= 3'h0;
         tmp_rdy_r  <= 1'b1;               // see RULE_07
      end
   end

   // ==========================================================
   // Control: mode select and hold
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= RST_MODE;
         hold_r <= RST_HOLD;
      end else if (wr_go && addr_r == A_CTRL && lane_r[0]) begin
         mode_r <= I_HWDATA[B_MODE];
         hold_r <= I_HWDATA[B_HOLD];
      end
   end

   // ==========================================================
   // Signed trim sum drives the tick generator
   logic signed [9:0] ofs_s;
   logic signed [9:0] tmp_s;
   logic signed [9:0] corr_sum;

   // Sign bit picks the direction of each correction
   always_comb begin
      ofs_s = ofs_sign_r ? $signed({2'h0, ofs_mag_r}) // see RULE_01
                         : -$signed({2'h0, ofs_mag_r});
      tmp_s = tmp_sign_r ? $signed({2'h0, tmp_mag_r}) // see RULE_05
                         : -$signed({2'h0, tmp_mag_r});
      corr_sum = ofs_s + tmp_s;            // see RULE_14
   end

   rtctrm_tick #(
      .CLK_HZ (CLK_HZ)
   ) u_tick (
      .i_clk   (I_CORE_CLK),
      .i_rst_n (rst_n),
      .i_corr  (corr_sum),
      .o_tick  (tick)
   );

   // Tick brought out on its own flop
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_SEC_TICK <= 1'b0;
      end else begin
         O_SEC_TICK <= tick;
      end
   end

   // ==========================================================
   // Counter low bytes; a bus write wins over the count step
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= {RST_CNT, RST_CNT};
      end else if (wr_go && addr_r == A_CNT_B0 && lane_r[0]) begin
         cnt_r[7:0] <= I_HWDATA[7:0];      // see RULE_12
      end else if (wr_go && addr_r == A_CNT_B1 && lane_r[0]) begin
         cnt_r[15:8] <= I_HWDATA[7:0];     // see RULE_12
      end else if (!mode_r && !hold_r && tick) begin
         cnt_r <= cnt_r + 16'h0001;        // see RULE_13
      end
   end

endmodule

// ---- tb/rtctrm_sva.sv ----
`timescale 1ns/10ps
module rtctrm_sva
   import rtctrm_pkg::*;
#(
   parameter int CLK_HZ = CLK_HZ_DEF
) (
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_ARST_N,
   input  wire logic        I_AUX_RST_N,
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   input  wire logic [31:0] O_HRDATA,
   input  wire logic        O_HREADYOUT,
   input  wire logic        O_HRESP,
   input  wire logic        O_SEC_TICK
);
   // ==========================================================
   // Tick gap bounds for corrections up to 480 ppm either way
   localparam longint SPAN = longint'(CLK_HZ) * 480 / 1000000;
   localparam int     LO   = CLK_HZ - int'(SPAN) - 1;
   localparam int     HI   = CLK_HZ + int'(SPAN) - 1;
   logic [31:0] gap_r;
   logic        seen_r;
   wire         tk = I_HSEL & I_HTRANS[1] & I_HREADY;
   wire         rd = tk & !I_HWRITE;
   wire  [7:0]  a  = I_HADDR[7:0];

   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_ARST_N);

   // Cycles since the last tick
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         gap_r  <= '0;
         seen_r <= 1'b0;
      end else if (O_SEC_TICK) begin
         gap_r  <= '0;
         seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 32'h1;
      end
   end

   okay_resp_a: assert property (O_HRESP == 1'b0)
      else $error("bus response not OKAY");
   read_wait_a: assert property (rd |=> !O_HREADYOUT ##1 O_HREADYOUT)
      else $error("read wait state wrong");
   write_nowait_a: assert property (tk && I_HWRITE |=> O_HREADYOUT)
      else $error("write stalled");
   rdata_hold_a: assert property (O_HREADYOUT && $past(O_HREADYOUT)
      |-> $stable(O_HRDATA)) else $error("read data moved");
   ofs_unused_a: assert property (rd && a == A_OFS_TRIM |-> ##2
      (O_HRDATA[31:16] == 16'h0 && O_HRDATA[14:8] == 7'h0))
      else $error("offset trim unused bits set");
   tmp_unused_a: assert property (rd && a == A_TMP_TRIM |-> ##2
      (O_HRDATA[31:16] == 16'h0 && O_HRDATA[12:8] == 5'h0))
      else $error("temperature trim unused bits set");
   count_byte_a: assert property (rd && (a == A_CNT_B0 ||
      a == A_CNT_B1) |-> ##2 O_HRDATA[31:8] == 24'h0)
      else $error("count byte wider than eight bits");
   unmapped_zero_a: assert property (rd && a >= 8'h14 |-> ##2
      O_HRDATA == 32'h0) else $error("unmapped read not zero");
   tick_pulse_a: assert property (O_SEC_TICK |=> !O_SEC_TICK)
      else $error("tick longer than one cycle");
   tick_gap_a: assert property (O_SEC_TICK && seen_r |->
      gap_r >= LO && gap_r <= HI) else $error("tick spacing out of range");
endmodule

bind rtctrm_top rtctrm_sva #(.CLK_HZ(CLK_HZ)) u_sva (
   .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N),
   .I_AUX_RST_N(I_AUX_RST_N), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
   .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE),
   .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
   .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
   .O_SEC_TICK(O_SEC_TICK));

// ---- tb/rtc_frequency_trim_regs_tb.sv ----
`timescale 1ns/10ps
module rtc_frequency_trim_regs_tb;
   import rtctrm_pkg::*;
   // ==========================================================
   // Signals and expected trim state
   localparam int CLK_SIM = 20000;
   logic        clk, arst_n, aux_n, hsel, hwrite, r, s, os, ts, tok;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  m, om, tm;
   logic        hrdy, hresp, tick;
   int          n_fail, tests_run, g;

   rtctrm_top #(.CLK_HZ(CLK_SIM)) dut (
      .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_AUX_RST_N(aux_n),
      .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
      .I_HREADY(hrdy), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy),
      .O_HRESP(hresp), .O_SEC_TICK(tick));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task end_of_test;
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      tests_run++;
      if (seen !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, seen);
      end
   endtask

   // Ready is read mid-cycle, so it is the value the next edge samples
   task wait_rdy;
      int k;
      k = 0;
      do begin
         @(negedge clk);
         r  = hrdy;
         rd = hrdata;
         k++;
         @(posedge clk);
      end while (r !== 1'b1 && k < 50);
      if (r !== 1'b1) chk("hready", 32'(r), 32'h1);
   endtask

   // One single AHB transfer: address phase, then data phase
   task xfer(input logic w, input logic [7:0] a, input logic [2:0] sz,
             input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      hsize  <= sz;
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy;
   endtask

   task tick_gap;
      g = 0;
      do begin
         @(negedge clk);
         g++;
      end while (tick !== 1'b1 && g < 30000);
   endtask

   function automatic int exp_period();
      int c;
      c = (os ? int'(om) : -int'(om)) + (ts ? int'(tm) : -int'(tm));
      return CLK_SIM - c * CLK_SIM / PPM_DIV;
   endfunction

   function automatic logic [31:0] exp_tmp();
      return {16'h0, ts, 1'b1, tok, 5'h0, tm};
   endfunction

   // ==========================================================
   // Main sequence
   initial begin
      {arst_n, aux_n, hsel, hwrite, os, ts, tok} = '0;
      {haddr, hwdata, htrans, om, tm} = '0;
      hsize = 3'h2;
      n_fail = 0;
      tests_run = 0;
      void'($urandom(32'h1e4992c0));
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      aux_n  <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(0, A_TMP_TRIM, 3'h2, 32'h0);
      chk("tmp_rst", rd, 32'h4000);
      for (int i = 0; i < 24; i++) begin
         s = 1'($urandom);
         m = (i % 12 < 2) ? 8'hf0 + 8'(i % 12) : 8'($urandom);
         if (i < 12) begin
            xfer(1, A_OFS_TRIM, 3'h2, {16'h0, s, 7'h7f, m});
            os = s;
            if (m <= MAG_LIMIT) om = m;
            xfer(0, A_OFS_TRIM, 3'h2, 32'h0);
            chk("ofs", rd, {16'h0, os, 7'h0, om});
         end else begin
            xfer(1, A_TMP_TRIM, 3'h2, {16'h0, s, 7'h7f, m});
            tok = (m <= MAG_LIMIT);
            if (tok) {ts, tm} = {s, m};
            repeat (6) @(posedge clk);
            xfer(0, A_TMP_TRIM, 3'h2, 32'h0);
            chk("tmp", rd, exp_tmp());
         end
      end
      xfer(1, A_TMP_TRIM, 3'h2, 32'h8010);
      xfer(0, A_TMP_TRIM, 3'h2, 32'h0);
      chk("busy", {31'h0, rd[B_TRDY]}, 32'h0);
      xfer(1, A_TMP_TRIM, 3'h2, 32'h8033);
      xfer(1, A_TMP_TRIM, 3'h2, 32'h8020);
      {ts, tm, tok} = {1'b1, 8'h33, 1'b0};
      repeat (6) @(posedge clk);
      xfer(0, A_TMP_TRIM, 3'h2, 32'h0);
      chk("refuse", rd, exp_tmp());
      xfer(1, A_TMP_TRIM + 8'h1, 3'h0, 32'h0);
      repeat (6) @(posedge clk);
      xfer(0, A_TMP_TRIM, 3'h2, 32'h0);
      chk("pend", rd & 32'hdfff, exp_tmp() & 32'hdfff);
      xfer(1, A_TMP_TRIM, 3'h0, 32'h22);
      {ts, tm, tok} = {1'b0, 8'h22, 1'b1};
      repeat (6) @(posedge clk);
      xfer(0, A_TMP_TRIM, 3'h2, 32'h0);
      chk("commit", rd, exp_tmp());
      xfer(0, 8'h20, 3'h2, 32'h0);
      chk("unmapped", rd, 32'h0);
      arst_n <= 1'b0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(0, A_TMP_TRIM, 3'h2, 32'h0);
      chk("keep", rd, exp_tmp());
      xfer(0, A_CTRL, 3'h2, 32'h0);
      chk("ctrl_rst", rd, 32'h3);
      xfer(1, A_CTRL, 3'h2, 32'h0);
      xfer(1, A_CNT_B0, 3'h2, 32'hff);
      xfer(1, A_CNT_B1, 3'h2, 32'h0);
      xfer(0, A_CNT_B0, 3'h2, 32'h0);
      chk("cnt0", rd, 32'hff);
      xfer(1, A_OFS_TRIM, 3'h2, 32'h80f0);
      {os, om} = {1'b1, 8'hf0};
      tick_gap;
      tick_gap;
      chk("period", g, exp_period());
      @(posedge clk);
      xfer(0, A_CNT_B0, 3'h2, 32'h0);
      chk("carry0", rd, 32'h01);
      xfer(0, A_CNT_B1, 3'h2, 32'h0);
      chk("carry1", rd, 32'h01);
      aux_n <= 1'b0;
      repeat (10) @(posedge clk);
      aux_n <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(0, A_OFS_TRIM, 3'h2, 32'h0);
      chk("ofs_aux", rd, 32'h0);
      xfer(0, A_TMP_TRIM, 3'h2, 32'h0);
      chk("tmp_aux", rd, 32'h4000);
      end_of_test;
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_of_test;
   end
endmodule
